//--- src/serial_flash_command_core.sv
// serial flash command core: select, clock and data pins sampled by ref_clk
// assumes the link clock is much slower than ref_clk (at least 8 ref_clk per period)
`timescale 1ns/1ps
module serial_flash_command_core #(
	parameter int ADDR_W = 19,
	parameter int PAGE_WRITE_TIME_NS = 1000000,
	parameter int STATUS_WRITE_TIME_NS = 1000000,
	parameter logic [7:0] MAKER_CODE = 8'hC5, // arbitrary value
	parameter logic [7:0] DEVICE_ID_HI = 8'hA6, // arbitrary value
	parameter logic [7:0] DEVICE_ID_LO = 8'h3C // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic select_n,
	input wire logic serial_clk,
	input wire logic dual_lane_low_in,
	input wire logic write_guard_n,
	output logic dual_lane_low_out,
	output logic dual_lane_low_oe,
	output logic dual_lane_high_out,
	output logic dual_lane_high_oe,
	output logic write_latch_flag,
	output logic cycle_active_flag
);
	localparam int PW_CYC = (PAGE_WRITE_TIME_NS + flash_cmd_pkg::CLK_PERIOD_NS - 1) / flash_cmd_pkg::CLK_PERIOD_NS;
	localparam int SW_CYC = (STATUS_WRITE_TIME_NS + flash_cmd_pkg::CLK_PERIOD_NS - 1) / flash_cmd_pkg::CLK_PERIOD_NS;
	localparam logic [31:0] PAGE_WRITE_CYCLES = 32'(PW_CYC < 1 ? 1 : PW_CYC);
	localparam logic [31:0] STATUS_WRITE_CYCLES = 32'(SW_CYC < 1 ? 1 : SW_CYC);

	// pin synchronisers: value moves once stages two and three agree
	logic [3:0] pin_raw;
	logic [3:0] pin_f;
	assign pin_raw = {write_guard_n, dual_lane_low_in, serial_clk, select_n};
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge ref_clk) begin
				s1 <= pin_raw[g];
				s2 <= s1;
				s3 <= s2;
				if (srst) begin
					pin_f[g] <= 1'b1;
				end else if (s2 == s3) begin
					pin_f[g] <= s3;
				end
			end
		end
	endgenerate

	logic sclk_q;
	logic cs_q;
	logic [6:0] in_sr;
	logic [2:0] bit_cnt;
	logic [3:0] byte_cnt;
	logic [7:0] cmd;
	logic [23:0] addr;
	logic [7:0] sw_data;
	logic out_on;
	logic [7:0] out_sr;
	logic [2:0] out_cnt;
	logic [1:0] id_idx;
	logic lock_bit;
	logic [2:0] prot;
	logic [31:0] busy_timer;
	logic commit_on;
	logic [7:0] commit_idx;
	logic [15:0] page_base;
	logic [7:0] mem [0:(1 << ADDR_W) - 1];
	logic [7:0] pbuf [0:flash_cmd_pkg::PAGE_BYTES - 1];
	logic [flash_cmd_pkg::PAGE_BYTES - 1:0] pmask;

	// decode
	wire cs_low = ~pin_f[0];
	wire cs_rise = pin_f[0] & ~cs_q;
	wire cs_fall = ~pin_f[0] & cs_q;
	wire sclk_rise = pin_f[1] & ~sclk_q & cs_low;
	wire sclk_fall = ~pin_f[1] & sclk_q & cs_low;
	wire [7:0] in_byte = {in_sr, pin_f[2]};
	wire byte_done = sclk_rise & (bit_cnt == 3'h7);
	wire [7:0] cur_cmd = (byte_cnt == 4'h0) ? in_byte : cmd;
	wire is_array_rd = (cur_cmd == flash_cmd_pkg::OP_READ) | (cur_cmd == flash_cmd_pkg::OP_FAST_READ)
		| (cur_cmd == flash_cmd_pkg::OP_DUAL_READ);
	wire is_id = (cur_cmd == flash_cmd_pkg::OP_ID_FULL) | (cur_cmd == flash_cmd_pkg::OP_ID_SHORT)
		| (cur_cmd == flash_cmd_pkg::OP_ID_DEV);
	wire is_st_rd = cur_cmd == flash_cmd_pkg::OP_STATUS_READ;
	wire [3:0] hdr_len = (cur_cmd == flash_cmd_pkg::OP_READ) ? flash_cmd_pkg::HDR_READ
		: ((cur_cmd == flash_cmd_pkg::OP_FAST_READ) | (cur_cmd == flash_cmd_pkg::OP_DUAL_READ))
		? flash_cmd_pkg::HDR_FAST
		: ((cur_cmd == flash_cmd_pkg::OP_ID_SHORT) | (cur_cmd == flash_cmd_pkg::OP_ID_DEV))
		? flash_cmd_pkg::HDR_READ : flash_cmd_pkg::HDR_ONE;
	wire hdr_end = byte_done & (byte_cnt == hdr_len - 4'h1);
	wire start_out = hdr_end & (is_st_rd | ((is_array_rd | is_id) & ~cycle_active_flag));
	wire is_dual = cmd == flash_cmd_pkg::OP_DUAL_READ;
	wire start_dual = cur_cmd == flash_cmd_pkg::OP_DUAL_READ;
	wire hw_lock = lock_bit & ~pin_f[3];
	wire [7:0] status_byte = {lock_bit, 2'b00, prot, write_latch_flag, cycle_active_flag};
	wire whole = bit_cnt == 3'h0;
	wire go_latch_set = cs_rise & whole & (byte_cnt == 4'h1) & (cmd == flash_cmd_pkg::OP_LATCH_SET);
	wire go_latch_clr = cs_rise & whole & (byte_cnt == 4'h1) & (cmd == flash_cmd_pkg::OP_LATCH_CLEAR);
	wire go_status_wr = cs_rise & whole & (byte_cnt == flash_cmd_pkg::LEN_STATUS_WRITE)
		& (cmd == flash_cmd_pkg::OP_STATUS_WRITE) & write_latch_flag & ~hw_lock & ~cycle_active_flag;
	wire go_page_wr = cs_rise & whole & (byte_cnt >= flash_cmd_pkg::MIN_PAGE_WRITE)
		& (cmd == flash_cmd_pkg::OP_PAGE_WRITE) & write_latch_flag & ~cycle_active_flag;
	wire page_data = byte_done & (byte_cnt >= flash_cmd_pkg::FIRST_DATA_BYTE)
		& (cmd == flash_cmd_pkg::OP_PAGE_WRITE) & ~cycle_active_flag;
	wire [7:0] id_byte = (cmd == flash_cmd_pkg::OP_ID_FULL)
		? ((id_idx == 2'h0) ? MAKER_CODE : (id_idx == 2'h1) ? DEVICE_ID_HI : DEVICE_ID_LO)
		: ((cmd == flash_cmd_pkg::OP_ID_SHORT) & (id_idx == 2'h0)) ? MAKER_CODE : DEVICE_ID_LO;
	wire out_array = (cmd == flash_cmd_pkg::OP_READ) | (cmd == flash_cmd_pkg::OP_FAST_READ) | is_dual;
	wire [7:0] next_byte = (cmd == flash_cmd_pkg::OP_STATUS_READ) ? status_byte
		: out_array ? mem[addr[ADDR_W - 1:0]] : id_byte;
	wire out_load = out_cnt == 3'h0;
	wire [7:0] ld_byte = out_load ? next_byte : out_sr;
	wire [1:0] next_id_idx = (cmd == flash_cmd_pkg::OP_ID_FULL) ? ((id_idx == 2'h2) ? 2'h0 : id_idx + 2'h1)
		: {1'b0, ~id_idx[0]};
	wire [23:0] commit_addr = {page_base, commit_idx};

	// serial input framing
	always_ff @(posedge ref_clk) begin
		sclk_q <= pin_f[1];
		cs_q <= pin_f[0];
		if (srst | cs_fall) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 4'h0;
		end else if (sclk_rise) begin
			in_sr <= in_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (byte_done & (byte_cnt != flash_cmd_pkg::BYTE_CNT_MAX)) begin
				byte_cnt <= byte_cnt + 4'h1;
			end
		end
	end

	// opcode, address and status write data capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmd <= 8'h00;
			addr <= 24'h000000;
			sw_data <= 8'h00;
		end else if (byte_done) begin
			if (byte_cnt == 4'h0) begin
				cmd <= in_byte;
			end
			if ((byte_cnt >= 4'h1) & (byte_cnt <= 4'h3)) begin
				addr <= {addr[15:0], in_byte};
			end
			if (byte_cnt == 4'h1) begin
				sw_data <= in_byte;
			end
			if (page_data) begin
				addr[7:0] <= addr[7:0] + 8'h01;
			end
		end else if (sclk_fall & out_on & out_load & out_array) begin
			addr <= addr + 24'h000001;
		end
	end

	// output shifter on falling link clock edges
	always_ff @(posedge ref_clk) begin
		if (srst | cs_rise | cs_fall) begin
			out_on <= 1'b0;
			dual_lane_high_oe <= 1'b0;
			dual_lane_low_oe <= 1'b0;
			out_cnt <= 3'h0;
			id_idx <= 2'h0;
		end else if (start_out) begin
			out_on <= 1'b1;
			dual_lane_high_oe <= 1'b1;
			dual_lane_low_oe <= start_dual;
		end else if (sclk_fall & out_on) begin
			out_cnt <= out_load ? (is_dual ? flash_cmd_pkg::BITS_DUAL_LAST : flash_cmd_pkg::BITS_SINGLE_LAST)
				: out_cnt - 3'h1;
			if (out_load & ~out_array) begin
				id_idx <= next_id_idx;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dual_lane_high_out <= 1'b0;
			dual_lane_low_out <= 1'b0;
			out_sr <= 8'h00;
		end else if (sclk_fall & out_on) begin
			dual_lane_high_out <= ld_byte[7];
			if (is_dual) begin
				dual_lane_low_out <= ld_byte[6];
			end
			out_sr <= is_dual ? {ld_byte[5:0], 2'b00} : {ld_byte[6:0], 1'b0};
		end
	end

	// status bits and self-timed cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			write_latch_flag <= 1'b0;
			cycle_active_flag <= 1'b0;
			busy_timer <= 32'h00000000;
			lock_bit <= flash_cmd_pkg::STATUS_LOCK_RST;
			prot <= flash_cmd_pkg::PROT_RST;
		end else if (cycle_active_flag) begin
			if (busy_timer == 32'h00000000) begin
				cycle_active_flag <= 1'b0;
				write_latch_flag <= go_latch_set;
			end else begin
				busy_timer <= busy_timer - 32'h00000001;
				if (go_latch_set) begin
					write_latch_flag <= 1'b1;
				end else if (go_latch_clr) begin
					write_latch_flag <= 1'b0;
				end
			end
		end else if (go_status_wr) begin
			cycle_active_flag <= 1'b1;
			busy_timer <= STATUS_WRITE_CYCLES - 32'h00000001;
			lock_bit <= sw_data[flash_cmd_pkg::ST_LOCK];
			prot <= sw_data[flash_cmd_pkg::ST_PROT_HI:flash_cmd_pkg::ST_PROT_LO];
		end else if (go_page_wr) begin
			cycle_active_flag <= 1'b1;
			busy_timer <= PAGE_WRITE_CYCLES - 32'h00000001;
		end else if (go_latch_set) begin
			write_latch_flag <= 1'b1;
		end else if (go_latch_clr) begin
			write_latch_flag <= 1'b0;
		end
	end

	// page buffer and commit into the array during the busy cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pmask <= '0;
			commit_on <= 1'b0;
			commit_idx <= 8'h00;
			page_base <= 16'h0000;
		end else if (go_page_wr) begin
			commit_on <= 1'b1;
			commit_idx <= 8'h00;
			page_base <= addr[23:8];
		end else if (commit_on) begin
			commit_idx <= commit_idx + 8'h01;
			if (commit_idx == 8'hFF) begin
				commit_on <= 1'b0;
				pmask <= '0;
			end
		end else if (cs_fall & ~cycle_active_flag) begin
			pmask <= '0;
		end else if (page_data) begin
			pmask[addr[7:0]] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (page_data) begin
			pbuf[addr[7:0]] <= in_byte;
		end
		if (commit_on & pmask[commit_idx]) begin
			mem[commit_addr[ADDR_W - 1:0]] <= pbuf[commit_idx];
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_latch_set: assert property (go_latch_set & ~cycle_active_flag |=> write_latch_flag)
		else $error("latch set command did not set the write latch");
	chk_latch_clear: assert property (go_latch_clr & ~cycle_active_flag |=> !write_latch_flag)
		else $error("latch clear command did not clear the write latch");
	chk_cycle_end: assert property ($fell(cycle_active_flag) && !$past(go_latch_set) |-> !write_latch_flag)
		else $error("write latch still set after self-timed cycle");
	chk_status_low: assert property (status_byte[6:5] == 2'b00 && status_byte[0] == cycle_active_flag)
		else $error("status reserved bits or busy bit wrong");
	chk_lock_refuse: assert property (cs_rise && hw_lock && !cycle_active_flag
		&& cmd == flash_cmd_pkg::OP_STATUS_WRITE |=> !cycle_active_flag)
		else $error("status write ran under hardware lock");
	chk_partial_byte: assert property (cs_rise && !whole && !cycle_active_flag |=> !cycle_active_flag)
		else $error("busy cycle started on partial byte");
	chk_busy_read: assert property (hdr_end && cur_cmd == flash_cmd_pkg::OP_READ && cycle_active_flag
		|=> !out_on)
		else $error("read accepted during busy cycle");
	chk_dual_lanes: assert property (sclk_fall && out_on && is_dual && !out_load
		|=> dual_lane_high_out == $past(out_sr[7]) && dual_lane_low_out == $past(out_sr[6]))
		else $error("dual lane bit order wrong");
	chk_page_wrap: assert property (page_data && addr[7:0] == 8'hFF
		|=> addr[7:0] == 8'h00 && addr[23:8] == $past(addr[23:8]))
		else $error("page write address did not wrap within page");
	chk_busy_hold: assert property ($rose(cycle_active_flag) && busy_timer > 32'h00000008
		|-> cycle_active_flag [*8])
		else $error("busy cycle ended too early");
	chk_addr_step: assert property (sclk_fall && out_on && out_load && out_array && !byte_done
		|=> addr == $past(addr) + 24'h000001)
		else $error("read address did not increment");
endmodule

//--- pkg/flash_cmd_pkg.sv
// constants of the serial flash command core: opcodes, status layout, lengths
// assumes a single 100 MHz core clock
package flash_cmd_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_READ = 8'h3B;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_ID_FULL = 8'h9F;
	localparam logic [7:0] OP_ID_SHORT = 8'h90;
	localparam logic [7:0] OP_ID_DEV = 8'hAB;
	localparam int ST_LOCK = 7;
	localparam int ST_PROT_HI = 4;
	localparam int ST_PROT_LO = 2;
	localparam logic STATUS_LOCK_RST = 1'b0;
	localparam logic [2:0] PROT_RST = 3'h0;
	localparam logic [3:0] HDR_ONE = 4'h1;
	localparam logic [3:0] HDR_READ = 4'h4;
	localparam logic [3:0] HDR_FAST = 4'h5;
	localparam logic [3:0] LEN_STATUS_WRITE = 4'h2;
	localparam logic [3:0] MIN_PAGE_WRITE = 4'h5;
	localparam logic [3:0] FIRST_DATA_BYTE = 4'h4;
	localparam logic [3:0] BYTE_CNT_MAX = 4'hF;
	localparam int PAGE_BYTES = 256;
	localparam logic [2:0] BITS_SINGLE_LAST = 3'h7;
	localparam logic [2:0] BITS_DUAL_LAST = 3'h3;
endpackage

//--- verif/spi_host_model.sv
// host side of the serial link: drives select, link clock and the data-in lane
// assumes ref_clk at 100 MHz; the link clock averages 125 ns and stands low between frames
`timescale 1ns/1ps
module spi_host_model (
	input wire logic ref_clk,
	output logic select_n,
	output logic serial_clk,
	output logic lane_low,
	input wire logic low_out,
	input wire logic low_oe,
	input wire logic high_out,
	input wire logic high_oe
);
	logic host_data = 1'b0;
	logic host_on = 1'b1;
	logic ph = 1'b0;
	logic prev_low = 1'b0;
	logic prev_high = 1'b0;
	logic high_wire;
	logic [7:0] rx_byte;
	event got;
	// released lanes show a pattern that changes every cycle
	assign lane_low = low_oe ? low_out : (host_on ? host_data : ~prev_low);
	assign high_wire = high_oe ? high_out : ~prev_high;
	always @(posedge ref_clk) begin
		prev_low <= lane_low;
		prev_high <= high_wire;
	end
	initial begin
		select_n = 1'b1;
		serial_clk = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// data set while the clock is low, both sides sample at the rising edge
	task automatic bit_clk(output logic hi, output logic lo);
		tick(6);
		hi = high_wire;
		lo = lane_low;
		serial_clk = 1'b1;
		ph = ~ph;
		tick(6 + ph);
		serial_clk = 1'b0;
	endtask
	// opcode and header go msb first, last byte cut to last_bits
	task automatic frame(input logic [7:0] tx [$], input int last_bits, input int n_rx, input bit dual);
		logic hi;
		logic lo;
		logic [7:0] r;
		tick(8);
		select_n = 1'b0;
		foreach (tx[i]) for (int b = 7; b >= 0; b--) begin
			if (i == tx.size() - 1 && 7 - b >= last_bits) break;
			host_data = tx[i][b];
			bit_clk(hi, lo);
		end
		host_on = 1'b0;
		repeat (n_rx) begin
			for (int b = 0; b < (dual ? 4 : 8); b++) begin
				bit_clk(hi, lo);
				r = dual ? {r[5:0], hi, lo} : {r[6:0], hi};
			end
			rx_byte = r;
			-> got;
		end
		tick(2);
		select_n = 1'b1;
		host_on = 1'b1;
	endtask
endmodule

//--- verif/serial_flash_command_core_tb_top.sv
// self-checking bench of the serial flash command core
// assumes the host model drives the link; read bytes are checked against a queue
`timescale 1ns/1ps
module serial_flash_command_core_tb_top;
	localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
	localparam logic [7:0] ID_HI = 8'h6B; // arbitrary value
	localparam logic [7:0] ID_LO = 8'h7C; // arbitrary value
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic write_guard_n = 1'b1;
	logic select_n;
	logic serial_clk;
	logic lane_low;
	logic low_out;
	logic low_oe;
	logic high_out;
	logic high_oe;
	logic latch;
	logic busy;
	int oe_count = 0;
	int oe_mark = 0;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] expq [$];
	logic [31:0] rng = 32'h0000000B;
	logic [7:0] d [3];
	serial_flash_command_core #(.PAGE_WRITE_TIME_NS(10000), .STATUS_WRITE_TIME_NS(3000),
		.MAKER_CODE(MAKER), .DEVICE_ID_HI(ID_HI), .DEVICE_ID_LO(ID_LO)) u_dut (.ref_clk(ref_clk),
		.srst(srst), .select_n(select_n), .serial_clk(serial_clk), .dual_lane_low_in(lane_low),
		.write_guard_n(write_guard_n), .dual_lane_low_out(low_out), .dual_lane_low_oe(low_oe),
		.dual_lane_high_out(high_out), .dual_lane_high_oe(high_oe), .write_latch_flag(latch),
		.cycle_active_flag(busy));
	spi_host_model u_host (.ref_clk(ref_clk), .select_n(select_n), .serial_clk(serial_clk), .lane_low(lane_low),
		.low_out(low_out), .low_oe(low_oe), .high_out(high_out), .high_oe(high_oe));
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error rx_byte expected %h seen %h", exp, seen);
		end
	endtask
	task automatic check_flags(input logic [1:0] exp);
		comparisons++;
		if ({latch, busy} !== exp) begin
			errors++;
			$display("Error latch_busy expected %b seen %b", exp, {latch, busy});
		end
	endtask
	task automatic rd(input logic [7:0] tx [$], input logic [7:0] exp [$], input bit dual);
		foreach (exp[i]) expq.push_back(exp[i]);
		u_host.frame(tx, 8, exp.size(), dual);
	endtask
	task automatic wr(input logic [7:0] tx [$], input int last_bits);
		u_host.frame(tx, last_bits, 0, 1'b0);
		u_host.tick(8);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
		u_host.tick(8);
	endtask
	initial forever begin
		@(u_host.got);
		check_byte(expq.size() ? expq.pop_front() : 8'hXX, u_host.rx_byte);
	end
	always @(posedge ref_clk) begin
		if (high_oe === 1'b1) oe_count <= oe_count + 1;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		u_host.tick(4);
		check_flags(2'b00);
		rd('{flash_cmd_pkg::OP_STATUS_READ}, '{8'h00, 8'h00}, 1'b0);
		wr('{flash_cmd_pkg::OP_LATCH_SET}, 8);
		check_flags(2'b10);
		wr('{flash_cmd_pkg::OP_LATCH_CLEAR}, 8);
		check_flags(2'b00);
		wr('{flash_cmd_pkg::OP_LATCH_SET}, 7);
		check_flags(2'b00);
		$display("test latch done");
		wr('{flash_cmd_pkg::OP_STATUS_WRITE, 8'hFF}, 8);
		check_flags(2'b00);
		wr('{flash_cmd_pkg::OP_LATCH_SET}, 8);
		wr('{flash_cmd_pkg::OP_STATUS_WRITE, 8'hFF}, 7);
		check_flags(2'b10);
		wr('{flash_cmd_pkg::OP_STATUS_WRITE, 8'hFF}, 8);
		rd('{flash_cmd_pkg::OP_STATUS_READ}, '{8'h9F}, 1'b0);
		wait_idle();
		check_flags(2'b00);
		rd('{flash_cmd_pkg::OP_STATUS_READ}, '{8'h9C}, 1'b0);
		write_guard_n = 1'b0;
		wr('{flash_cmd_pkg::OP_LATCH_SET}, 8);
		wr('{flash_cmd_pkg::OP_STATUS_WRITE, 8'h00}, 8);
		check_flags(2'b10);
		write_guard_n = 1'b1;
		wr('{flash_cmd_pkg::OP_STATUS_WRITE, 8'h00}, 8);
		wait_idle();
		rd('{flash_cmd_pkg::OP_STATUS_READ}, '{8'h00}, 1'b0);
		$display("test status write done");
		foreach (d[i]) d[i] = rnd();
		wr('{flash_cmd_pkg::OP_LATCH_SET}, 8);
		wr('{flash_cmd_pkg::OP_PAGE_WRITE, 8'h00, 8'h01, 8'hFE, d[0], d[1], d[2]}, 8);
		check_flags(2'b11);
		oe_mark = oe_count;
		wr('{flash_cmd_pkg::OP_READ, 8'h00, 8'h01, 8'h00, 8'h00}, 8);
		check_byte(8'h00, {7'h00, oe_count != oe_mark});
		rd('{flash_cmd_pkg::OP_STATUS_READ}, '{8'h03}, 1'b0);
		wait_idle();
		check_flags(2'b00);
		rd('{flash_cmd_pkg::OP_READ, 8'h00, 8'h01, 8'h00}, '{d[2]}, 1'b0);
		rd('{flash_cmd_pkg::OP_READ, 8'h00, 8'h01, 8'hFE}, '{d[0], d[1]}, 1'b0);
		rd('{flash_cmd_pkg::OP_FAST_READ, 8'h00, 8'h01, 8'hFE, 8'h00}, '{d[0], d[1]}, 1'b0);
		rd('{flash_cmd_pkg::OP_DUAL_READ, 8'h00, 8'h01, 8'hFE, 8'h00}, '{d[0], d[1]}, 1'b1);
		$display("test array done");
		rd('{flash_cmd_pkg::OP_ID_FULL}, '{MAKER, ID_HI, ID_LO}, 1'b0);
		rd('{flash_cmd_pkg::OP_ID_SHORT, 8'h00, 8'h00, 8'h00}, '{MAKER, ID_LO}, 1'b0);
		rd('{flash_cmd_pkg::OP_ID_DEV, 8'h00, 8'h00, 8'h00}, '{ID_LO}, 1'b0);
		$display("test id done");
		u_host.tick(20);
		give_verdict();
	end
endmodule
